// ===== core/qspi_pkg.sv
/*
 * Shared constants, command and answer carriers, and state codes of the
 * quad serial flash port.
 * Assumes one or two quad serial flash parts that accept a quad-wide
 * opcode, address and data phase.
 */
package qspi_pkg;

  // Frame geometry: widths in bits, phase lengths in nibbles on the four data lines
  localparam int          DATA_W        = 32;
  localparam int          ADDR_W        = 24;
  localparam logic [4:0]  NIB_HEAD      = 5'h08;   // opcode (2) + address (6)
  localparam logic [4:0]  NIB_DATA      = 5'h08;
  localparam logic [4:0]  NIB_OPCODE    = 5'h02;

  // Direct-mode read sequence; opcode and dummy count may differ per part
  localparam logic [7:0]  DIRECT_OPCODE = 8'hEB;
  localparam logic [3:0]  DIRECT_DUMMY  = 4'h4;

  // Values after reset, and the other output-enable codes
  localparam logic [3:0]  CNT_RST       = 4'h0;
  localparam logic [4:0]  NIB_RST       = 5'h00;
  localparam logic [1:0]  CS_N_RST      = 2'h3;
  localparam logic [3:0]  OE_NONE       = 4'h0;
  localparam logic [3:0]  OE_D0         = 4'h1;
  localparam logic [3:0]  OE_ALL        = 4'hF;

  typedef struct packed {
    logic                cs_sel;    // 0: first flash, 1: second flash
    logic                write;     // 1: data phase drives the lines
    logic [7:0]          opcode;
    logic [ADDR_W-1:0]   addr;
    logic [3:0]          dummy;     // dummy nibbles before read data
    logic [DATA_W-1:0]   wdata;
    logic [3:0]          lead;      // clock periods, cs active to first fall
    logic [3:0]          lag;       // clock periods, last fall to cs inactive
  } cmd_s;

  typedef struct packed {
    logic [DATA_W-1:0]   word;
    logic                direct;    // answer to a direct-mode read
  } resp_s;

  typedef enum logic [4:0] {
    L_IDLE  = 5'b00001,
    L_PRE   = 5'b00010,
    L_LEAD  = 5'b00100,
    L_SHIFT = 5'b01000,
    L_LAG   = 5'b10000
  } link_state_e;

  typedef enum logic [1:0] {
    S_IDLE = 2'b01,
    S_BUSY = 2'b10
  } sys_state_e;

endpackage

// ===== core/qspi_resp_buf.sv
/*
 * Small first-in first-out buffer for answer words, valid and ready on
 * both sides.
 * Assumes one clock; DEPTH is a power of two.
 */
`timescale 1ns/1ps
module qspi_resp_buf #(
  parameter int W     = 33,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          arst_n,
  // Fill side
  input  wire logic          in_valid,
  output logic               in_ready,
  input  wire logic [W-1:0]  in_data,
  // Drain side
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic [W-1:0]       out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem_r [DEPTH];
  logic [W-1:0]  mem_nxt [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          push, pop;

  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    mem_nxt = mem_r;
    wp_nxt  = wp_r;
    rp_nxt  = rp_r;
    cnt_nxt = cnt_r;
    if (push) begin
      mem_nxt[wp_r] = in_data;
      wp_nxt        = wp_r + 1'b1;
    end
    if (pop) begin
      rp_nxt = rp_r + 1'b1;
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      mem_r <= mem_nxt;
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

endmodule // qspi_resp_buf

// ===== core/quad_serial_flash_port.sv
/*
 * Quad serial flash port: direct-mode reads and indirect commands from
 * the system clock, serial frames on the link clock, read data captured
 * on the falling edges of the looped-back serial clock.
 * Assumes link_clk runs free and the board returns sclk on sclk_lb.
 */
`timescale 1ns/1ps
module quad_serial_flash_port
  import qspi_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  // System clock and reset
  input  wire logic                clock,
  input  wire logic                arst_n,
  // Direct-mode read window
  input  wire logic                dir_valid,
  output logic                     dir_ready,
  input  wire logic                dir_cs_sel,
  input  wire logic [ADDR_W-1:0]   dir_addr,
  // Indirect command
  input  wire logic                ind_valid,
  output logic                     ind_ready,
  input  wire cmd_s                ind_cmd,
  // Select timing for direct reads
  input  wire logic [3:0]          dir_lead,
  input  wire logic [3:0]          dir_lag,
  // Answers
  output logic                     resp_valid,
  input  wire logic                resp_ready,
  output resp_s                    resp_data,
  // Link clock and flash pins
  input  wire logic                link_clk,
  input  wire logic                sclk_lb,
  output logic                     sclk,
  output logic [1:0]               cs_n,
  output logic [3:0]               d_o,
  output logic [3:0]               d_oe,
  input  wire logic [3:0]          d_i
);

  // System domain state
  sys_state_e  sst_r, sst_nxt;
  cmd_s        hold_r, hold_nxt;
  logic        direct_r, direct_nxt;
  logic        req_tgl_r, req_tgl_nxt;
  logic        ack_s1_r, ack_s2_r, ack_seen_r, ack_seen_nxt;
  logic        buf_in_valid, buf_in_ready;
  resp_s       buf_in_data;
  cmd_s        dir_cmd;

  // Link domain state
  link_state_e lst_r, lst_nxt;
  cmd_s        lcmd_r, lcmd_nxt;
  logic        ph_r, ph_nxt;
  logic [3:0]  cnt_r, cnt_nxt;
  logic [4:0]  nib_r, nib_nxt;
  logic        req_s1_r, req_s2_r, req_seen_r, req_seen_nxt;
  logic        ack_tgl_r, ack_tgl_nxt;
  logic [DATA_W-1:0] result_r, result_nxt;
  logic        sclk_r, sclk_nxt;
  logic [1:0]  cs_n_r, cs_n_nxt;
  logic [3:0]  d_o_r, d_o_nxt, d_oe_r, d_oe_nxt;
  logic [4:0]  last_nib, data_idx;
  logic [3:0]  nib_val;
  logic [31:0] head_word;

  // Loopback capture domain
  logic [DATA_W-1:0] cap_r, cap_nxt;

  // Direct reads are fixed quad reads of one word
  always_comb begin
    dir_cmd        = '0;
    dir_cmd.cs_sel = dir_cs_sel;
    dir_cmd.write  = 1'b0;
    dir_cmd.opcode = DIRECT_OPCODE;
    dir_cmd.addr   = dir_addr;
    dir_cmd.dummy  = DIRECT_DUMMY;
    dir_cmd.lead   = dir_lead;
    dir_cmd.lag    = dir_lag;
  end

  // One frame in flight; a free buffer slot is needed before issue, so the
  // answer always finds room even while the reader stalls
  assign dir_ready = (sst_r == S_IDLE) & buf_in_ready;
  assign ind_ready = (sst_r == S_IDLE) & buf_in_ready & ~dir_valid;

  assign buf_in_valid       = (sst_r == S_BUSY) & (ack_s2_r != ack_seen_r);
  assign buf_in_data.word   = result_r;
  assign buf_in_data.direct = direct_r;

  always_comb begin
    sst_nxt      = sst_r;
    hold_nxt     = hold_r;
    direct_nxt   = direct_r;
    req_tgl_nxt  = req_tgl_r;
    ack_seen_nxt = ack_seen_r;
    case (sst_r)
      S_IDLE: begin
        if (dir_valid && dir_ready) begin
          hold_nxt    = dir_cmd;
          direct_nxt  = 1'b1;
          req_tgl_nxt = ~req_tgl_r;
          sst_nxt     = S_BUSY;
        end else if (ind_valid && ind_ready) begin
          hold_nxt    = ind_cmd;
          direct_nxt  = 1'b0;
          req_tgl_nxt = ~req_tgl_r;
          sst_nxt     = S_BUSY;
        end
      end
      S_BUSY: begin
        if (buf_in_valid) begin
          ack_seen_nxt = ack_s2_r;
          sst_nxt      = S_IDLE;
        end
      end
      default: begin
        sst_nxt = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sst_r      <= S_IDLE;
      hold_r     <= '0;
      direct_r   <= 1'b0;
      req_tgl_r  <= 1'b0;
      ack_s1_r   <= 1'b0;
      ack_s2_r   <= 1'b0;
      ack_seen_r <= 1'b0;
    end else begin
      sst_r      <= sst_nxt;
      hold_r     <= hold_nxt;
      direct_r   <= direct_nxt;
      req_tgl_r  <= req_tgl_nxt;
      ack_s1_r   <= ack_tgl_r;
      ack_s2_r   <= ack_s1_r;
      ack_seen_r <= ack_seen_nxt;
    end
  end

  qspi_resp_buf #(
    .W     ($bits(resp_s)),
    .DEPTH (BUF_DEPTH)
  ) u_resp_buf (
    .clock     (clock),
    .arst_n    (arst_n),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (buf_in_data),
    .out_valid (resp_valid),
    .out_ready (resp_ready),
    .out_data  (resp_data)
  );

  // Read data shift in on every falling edge of the returned clock, so the
  // board round trip drops out of the capture timing
  always_comb begin
    cap_nxt = {cap_r[DATA_W-5:0], d_i};
  end

  always_ff @(negedge sclk_lb or negedge arst_n) begin
    if (!arst_n) begin
      cap_r <= '0;
    end else begin
      cap_r <= cap_nxt;
    end
  end

  // Nibble for the next shift position, so a new nibble leaves with the
  // falling edge and stands still across the following rising edge
  assign last_nib  = NIB_HEAD + {1'b0, lcmd_r.dummy} + NIB_DATA - 5'h01;
  assign data_idx  = nib_nxt - NIB_HEAD - {1'b0, lcmd_nxt.dummy};
  assign head_word = {lcmd_nxt.opcode, lcmd_nxt.addr};

  always_comb begin
    logic [31:0] sh;
    sh = '0;
    if (nib_nxt < NIB_HEAD) begin
      sh = head_word << {nib_nxt, 2'b00};
    end else if (nib_nxt >= NIB_HEAD + {1'b0, lcmd_nxt.dummy}) begin
      sh = lcmd_nxt.wdata << {data_idx, 2'b00};
    end
    nib_val = sh[31:28];
  end

  // Each serial period is two link cycles: low half, then high half; the
  // state leaves L_IDLE at once, otherwise only moves at the end of a high half
  always_comb begin
    lst_nxt      = lst_r;
    lcmd_nxt     = lcmd_r;
    ph_nxt       = ~ph_r;
    cnt_nxt      = cnt_r;
    nib_nxt      = nib_r;
    req_seen_nxt = req_seen_r;
    ack_tgl_nxt  = ack_tgl_r;
    result_nxt   = result_r;
    case (lst_r)
      L_IDLE: begin
        ph_nxt = 1'b0;
        if (req_s2_r != req_seen_r) begin
          lcmd_nxt     = hold_r;
          req_seen_nxt = req_s2_r;
          nib_nxt      = NIB_RST;
          lst_nxt      = L_PRE;
        end
      end
      L_PRE: begin
        if (ph_r) begin
          if (lcmd_r.lead <= 4'h1) begin
            lst_nxt = L_SHIFT;
          end else begin
            cnt_nxt = lcmd_r.lead - 4'h1;
            lst_nxt = L_LEAD;
          end
        end
      end
      L_LEAD: begin
        if (ph_r) begin
          if (cnt_r <= 4'h1) begin
            lst_nxt = L_SHIFT;
          end else begin
            cnt_nxt = cnt_r - 4'h1;
          end
        end
      end
      L_SHIFT: begin
        if (ph_r) begin
          if (nib_r == last_nib) begin
            cnt_nxt = (lcmd_r.lag == 4'h0) ? 4'h1 : lcmd_r.lag;
            lst_nxt = L_LAG;
          end else begin
            nib_nxt = nib_r + 5'h01;
          end
        end
      end
      L_LAG: begin
        // At least one lag period lets the capture settle before it is read
        if (ph_r) begin
          if (cnt_r <= 4'h1) begin
            result_nxt  = lcmd_r.write ? '0 : cap_r;
            ack_tgl_nxt = ~ack_tgl_r;
            lst_nxt     = L_IDLE;
          end else begin
            cnt_nxt = cnt_r - 4'h1;
          end
        end
      end
      default: begin
        lst_nxt = L_IDLE;
      end
    endcase
  end

  // Pin values follow the next state so every pin leaves a flip-flop
  always_comb begin
    sclk_nxt = (lst_nxt == L_SHIFT) & ph_nxt;
    cs_n_nxt = CS_N_RST;
    d_oe_nxt = OE_NONE;
    d_o_nxt  = d_o_r;
    if (lst_nxt == L_PRE) begin
      d_oe_nxt = OE_D0;
      d_o_nxt  = nib_val;
    end else if (lst_nxt == L_LEAD || lst_nxt == L_SHIFT || lst_nxt == L_LAG) begin
      cs_n_nxt[lcmd_nxt.cs_sel] = 1'b0;
      d_o_nxt  = nib_val;
      if (nib_nxt < NIB_HEAD || lcmd_nxt.write) begin
        d_oe_nxt = OE_ALL;
      end
      if (lst_nxt == L_LAG && !lcmd_nxt.write) begin
        d_oe_nxt = OE_NONE;
      end
    end
  end

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      lst_r      <= L_IDLE;
      lcmd_r     <= '0;
      ph_r       <= 1'b0;
      cnt_r      <= CNT_RST;
      nib_r      <= NIB_RST;
      req_s1_r   <= 1'b0;
      req_s2_r   <= 1'b0;
      req_seen_r <= 1'b0;
      ack_tgl_r  <= 1'b0;
      result_r   <= '0;
      sclk_r     <= 1'b0;
      cs_n_r     <= CS_N_RST;
      d_o_r      <= OE_NONE;
      d_oe_r     <= OE_NONE;
    end else begin
      lst_r      <= lst_nxt;
      lcmd_r     <= lcmd_nxt;
      ph_r       <= ph_nxt;
      cnt_r      <= cnt_nxt;
      nib_r      <= nib_nxt;
      req_s1_r   <= req_tgl_r;
      req_s2_r   <= req_s1_r;
      req_seen_r <= req_seen_nxt;
      ack_tgl_r  <= ack_tgl_nxt;
      result_r   <= result_nxt;
      sclk_r     <= sclk_nxt;
      cs_n_r     <= cs_n_nxt;
      d_o_r      <= d_o_nxt;
      d_oe_r     <= d_oe_nxt;
    end
  end

  assign sclk = sclk_r;
  assign cs_n = cs_n_r;
  assign d_o  = d_o_r;
  assign d_oe = d_oe_r;

endmodule // quad_serial_flash_port

// ===== sim/qspi_port_checker.sv
/* Checker of the flash pins and the request handshakes.
   Bound to the port's top module; sees its ports only. */
`timescale 1ns/1ps
module qspi_port_checker
  import qspi_pkg::*;
(
  // Clocks and reset
  input wire logic       clock,
  input wire logic       arst_n,
  input wire logic       link_clk,
  // Requests and answers
  input wire logic       dir_valid,
  input wire logic       dir_ready,
  input wire logic       ind_ready,
  input wire logic       resp_valid,
  // Flash pins
  input wire logic       sclk,
  input wire logic [1:0] cs_n,
  input wire logic [3:0] d_o,
  input wire logic [3:0] d_oe
);
  // Line zero alone for one period, then select with all lines
  sequence s_lead_in;
    (d_oe == OE_D0 && &cs_n) [*2] ##1 (d_oe == OE_ALL && !(&cs_n));
  endsequence
  sequence s_take;
    dir_valid && dir_ready;
  endsequence

  a_one_select: assert property (@(posedge link_clk) disable iff (!arst_n)
    cs_n != 2'h0) else $error("both selects low");
  a_idle_low: assert property (@(posedge link_clk) disable iff (!arst_n)
    &cs_n |-> !sclk) else $error("clock high while idle");
  a_data_steady: assert property (@(posedge link_clk) disable iff (!arst_n)
    sclk |-> $stable(d_o) && $stable(d_oe)) else $error("data moved, clock high");
  a_pre_period: assert property (@(posedge link_clk) disable iff (!arst_n)
    $rose(d_oe == OE_D0) |-> s_lead_in) else $error("line zero lead wrong");
  a_oe_release: assert property (@(posedge link_clk) disable iff (!arst_n)
    $rose(&cs_n) |-> d_oe == OE_NONE) else $error("lines kept after select");
  a_lead_min: assert property (@(posedge link_clk) disable iff (!arst_n)
    $rose(sclk) |-> $past(cs_n) != 2'h3) else $error("select lead short");
  a_lag_min: assert property (@(posedge link_clk) disable iff (!arst_n)
    $fell(sclk) |-> !(&cs_n) ##1 !(&cs_n)) else $error("select lag short");
  a_one_frame: assert property (@(posedge clock) disable iff (!arst_n)
    s_take |=> !dir_ready && !ind_ready) else $error("second request taken");
  a_answer_due: assert property (@(posedge clock) disable iff (!arst_n)
    s_take ##0 !resp_valid |-> ##[1:400] resp_valid) else $error("no answer");
endmodule // qspi_port_checker

// ===== sim/qspi_flash_model.sv
/* Behavioural quad flash on either select; answers reads by address.
   Assumes the bench sets direction and dummy count per frame. */
`timescale 1ns/1ps
module qspi_flash_model (
  // Pins
  input  wire logic        sclk,
  input  wire logic [1:0]  cs_n,
  input  wire logic [3:0]  d_o,
  input  wire logic [3:0]  d_oe,
  output logic [3:0]       d_i,
  // Frame setup and record
  input  wire logic        rd,
  input  wire logic [3:0]  dummy,
  output logic [31:0]      head,
  output logic [31:0]      wword
);
  int          nr = 0;
  int          nf = 0;
  logic        fdrv = 1'b0;
  logic [3:0]  fd = 4'h0;
  logic [31:0] word;

  // Lines that neither side drives show the inverse of the last nibble, never a held value
  assign d_i  = (d_oe & d_o) | (~d_oe & (fdrv ? fd : ~fd));
  assign word = {head[7:0] ^ 8'h5A, head[23:0]};

  always @(negedge cs_n[0] or negedge cs_n[1]) begin
    nr = 0;
    nf = 0;
  end
  always @(posedge sclk) begin
    if (nr < 8) head = {head[27:0], d_o};
    else if (nr >= 8 + dummy) wword = {wword[27:0], d_o};
    nr++;
  end
  // Launch just after a fall, past the hold the port needs
  always @(negedge sclk) begin
    nf++;
    if (rd && nf >= 8 + dummy && nf < 16 + dummy) begin
      fd   <= #2 word[4 * (15 + dummy - nf) +: 4];
      fdrv <= #2 1'b1;
    end
  end
  always @(posedge cs_n[0] or posedge cs_n[1]) fdrv <= #2 1'b0;
endmodule // qspi_flash_model

// ===== sim/quad_serial_flash_port_tb.sv
/* Bench: random direct and indirect frames against the flash model,
   pin timing measured per frame. Assumes package, port and model. */
`timescale 1ns/1ps
module quad_serial_flash_port_tb
  import qspi_pkg::*;
();
  logic              clock = 1'b0, arst_n = 1'b0, link_clk = 1'b0;
  logic              dir_valid = 1'b0, ind_valid = 1'b0, dir_cs_sel = 1'b0;
  logic [ADDR_W-1:0] dir_addr = '0;
  cmd_s              ind_cmd = '0;
  logic [3:0]        dir_lead = 4'h0, dir_lag = 4'h0, dummy = 4'h0;
  logic              resp_ready = 1'b0, rd = 1'b0, stall = 1'b1;
  logic              dir_ready, ind_ready, resp_valid, sclk, sclk_lb;
  logic [1:0]        cs_n, csl;
  logic [3:0]        d_o, d_oe, d_i;
  logic [31:0]       head, wword;
  resp_s             resp_data;
  cmd_s              fq[$];
  resp_s             rq[$];
  int                n_fail = 0, n_compared = 0, nfall = 0;
  logic [63:0]       seed = 64'h15285;
  time               t_cs, t_f1, t_fl;

  always #10 clock = ~clock;
  initial begin
    #3 link_clk = 1'b1;
    forever #15 link_clk = ~link_clk;
  end
  assign #1 sclk_lb = sclk;

  quad_serial_flash_port u_dut (.clock, .arst_n, .dir_valid, .dir_ready, .dir_cs_sel,
    .dir_addr, .ind_valid, .ind_ready, .ind_cmd, .dir_lead, .dir_lag, .resp_valid,
    .resp_ready, .resp_data, .link_clk, .sclk_lb, .sclk, .cs_n, .d_o, .d_oe, .d_i);
  qspi_flash_model u_flash (.sclk, .cs_n, .d_o, .d_oe, .d_i, .rd, .dummy, .head, .wword);

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 7;
    seed ^= seed << 17;
    return seed[31:0];
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Waits for idle first so the model's frame setup never changes mid-frame
  task automatic req(input logic d, input cmd_s c);
    int k;
    for (k = 0; k < 400 && !(d ? dir_ready : ind_ready); k++) @(negedge clock);
    if (k == 400) n_fail++;
    {rd, dummy} = {!c.write, c.dummy};
    fq.push_back(c);
    rq.push_back('{word: c.write ? 32'h0 : {c.addr[7:0] ^ 8'h5A, c.addr}, direct: d});
    {dir_cs_sel, dir_addr, dir_lead, dir_lag} = {c.cs_sel, c.addr, c.lead, c.lag};
    ind_cmd = c;
    {dir_valid, ind_valid} = {d, !d};
    @(negedge clock);
    {dir_valid, ind_valid} = 2'h0;
  endtask

  task automatic frame_end(input cmd_s c);
    check(csl, c.cs_sel ? 2'h1 : 2'h2);
    check(t_f1 - t_cs, 60 * (c.lead > 0 ? c.lead : 1));
    check($time - t_fl, 60 * (c.lag > 0 ? c.lag : 1));
    check(nfall, 16 + c.dummy);
    check(head, {c.opcode, c.addr});
    if (c.write) check(wword, c.wdata);
  endtask

  always @(negedge cs_n[0] or negedge cs_n[1]) begin
    t_cs = $time;
    csl = cs_n;
    nfall = 0;
  end
  always @(negedge sclk) begin
    if (nfall == 0) t_f1 = $time;
    t_fl = $time;
    nfall++;
  end
  always @(posedge cs_n[0] or posedge cs_n[1]) begin
    if (arst_n && fq.size() > 0) frame_end(fq.pop_front());
  end

  always @(negedge clock) resp_ready <= !stall && 1'(rnd());
  always @(posedge clock) begin
    if (arst_n && resp_valid === 1'b1 && resp_ready) begin
      check(rq.size() > 0, 1);
      check(resp_data, rq.pop_front());
    end
  end

  task automatic drain();
    for (int k = 0; k < 3000 && rq.size() > 0; k++) @(negedge clock);
    check(rq.size(), 0);
  endtask

  initial begin
    cmd_s c;
    repeat (2) @(negedge clock);
    arst_n = 1'b1;
    check({dir_ready, ind_ready, resp_valid, sclk, cs_n, d_oe}, 10'h330);
    $display("test reset done");
    stall = 1'b0;
    // Even passes direct, odd indirect; first two at the lead/lag extremes
    for (int i = 0; i < 12; i++) begin
      c.cs_sel = 1'(rnd());
      c.write  = (i % 4 == 3);
      c.opcode = i[0] ? 8'(rnd()) : DIRECT_OPCODE;
      c.addr   = 24'(rnd());
      c.dummy  = c.write ? 4'h0 : i[0] ? 4'(rnd() % 8) : DIRECT_DUMMY;
      c.wdata  = rnd();
      c.lead   = i == 0 ? 4'h0 : i == 1 ? 4'hF : 4'(rnd() % 4);
      c.lag    = i == 0 ? 4'h0 : i == 1 ? 4'hF : 4'(rnd() % 4);
      req(!i[0], c);
    end
    drain();
    $display("test traffic done");
    stall = 1'b1;
    {c.write, c.opcode, c.dummy} = {1'b0, DIRECT_OPCODE, DIRECT_DUMMY};
    repeat (2) begin
      c.addr = 24'(rnd());
      req(1'b1, c);
    end
    repeat (300) @(negedge clock);
    check({dir_ready, ind_ready, resp_valid}, 3'h1);
    stall = 1'b0;
    drain();
    $display("test fill done");
    give_verdict();
  end

  initial begin
    // Tests need a few thousand cycles; ample margin, well below the cap
    #(20000 * 20);
    n_fail++;
    give_verdict();
  end
endmodule // quad_serial_flash_port_tb

bind quad_serial_flash_port qspi_port_checker u_chk (.clock, .arst_n, .link_clk,
  .dir_valid, .dir_ready, .ind_ready, .resp_valid, .sclk, .cs_n, .d_o, .d_oe);
